// >>> mda_hour_counter.sv
// Shared constants and types of the monitor and display block, and its hour accumulator.
// Assumes one clock with a synchronous active-high reset and a clock enable.
`default_nettype none

package mda_pkg;
  localparam logic [7:0]  ADDR_MON_SEL    = 8'h00;
  localparam logic [7:0]  ADDR_ENERGY_CLR = 8'h04;
  localparam logic [7:0]  ADDR_SHIFT      = 8'h08;
  localparam logic [7:0]  ADDR_RUN_CLR    = 8'h0c;
  localparam logic [7:0]  ADDR_ON_HOURS   = 8'h10;
  localparam logic [7:0]  ADDR_RUN_HOURS  = 8'h14;
  localparam logic [7:0]  ADDR_ENERGY     = 8'h18;
  localparam logic [7:0]  ADDR_PANEL_E    = 8'h1c;
  localparam logic [7:0]  ADDR_PU_E       = 8'h20;
  localparam logic [7:0]  ADDR_SERIAL_E   = 8'h24;
  localparam logic [15:0] SEL_SEQ         = 16'h0000;
  localparam logic [15:0] SEL_THERMAL     = 16'h000a;
  localparam logic [15:0] SEL_ON_HOURS    = 16'h0014;
  localparam logic [15:0] SEL_RUN_HOURS   = 16'h0017;
  localparam logic [15:0] SEL_ENERGY      = 16'h0019;
  localparam logic [15:0] SEL_IO_MAP      = 16'h0037;
  localparam logic [15:0] SEL_THERMISTOR  = 16'h0040;
  localparam logic [15:0] SEL_SET_FREQ    = 16'h0064;
  localparam logic [15:0] RANGE_SMALL     = 16'h000a;
  localparam logic [15:0] RANGE_WIDE      = 16'h270f;
  localparam logic [15:0] SHIFT_WRAP      = 16'h270f;
  localparam logic [15:0] SHIFT_MAX       = 16'h0004;
  localparam logic [15:0] PANEL_MAX       = 16'h270f;
  localparam logic [15:0] HOUR_PANEL_WRAP = 16'hfffa;
  localparam logic [15:0] HOUR_PANEL_DIV  = 16'h000a;
  localparam logic [15:0] THERM_MIN       = 16'h000a;
  localparam logic [15:0] THERM_MAX       = 16'h0c4e;
  localparam logic [15:0] SERIAL_MAX      = 16'hffff;
  localparam logic [23:0] ENERGY_MAX      = 24'h98967f;
  localparam logic [23:0] PANEL_E_2DEC    = 24'h00270f;
  localparam logic [23:0] PANEL_E_1DEC    = 24'h01869f;
  localparam logic [23:0] PANEL_E_0DEC    = 24'h0f423f;
  localparam logic [23:0] E_PER_KWH       = 24'h000064;
  localparam logic [23:0] E_TEN           = 24'h00000a;
  localparam logic [1:0]  DEC_NONE        = 2'h0;
  localparam logic [1:0]  DEC_ONE         = 2'h1;
  localparam logic [1:0]  DEC_TWO         = 2'h2;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned HOLD_MS         = 1000;
  localparam int unsigned HOUR_S          = 3600;
  localparam int unsigned HOLD_CYCLES     = HOLD_MS * 1000 * CLK_MHZ;
  localparam longint unsigned HOUR_CYCLES = longint'(HOUR_S) * 64'd1000000 * longint'(CLK_MHZ);

  typedef struct packed {
    logic        running;
    logic        fault;
    logic        output_stop_input;
    logic        autotune;
    logic        motor_thermistor_on;
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic [15:0] max_freq;
    logic [15:0] min_freq;
    logic [15:0] jump_lo;
    logic [15:0] jump_hi;
    logic [15:0] out_current;
    logic [15:0] out_voltage;
    logic [15:0] out_power;
    logic [15:0] motor_thermal;
    logic [15:0] transistor_thermal;
    logic [15:0] tuning_status;
    logic [15:0] thermistor_res;
    logic [7:0]  in_terms;
    logic [7:0]  out_terms;
  } mda_drive_t;

  typedef enum logic [1:0] {SLOT_FREQ, SLOT_CURRENT, SLOT_THIRD, SLOT_FAULT} mda_slot_t;

  typedef struct packed {
    logic [15:0] value;
    logic [1:0]  decimals;
    logic        dashes;
    logic        io_mode;
    logic [15:0] segments;
    logic        hz_on;
    logic        hz_flash;
    logic [1:0]  slot;
  } mda_panel_t;
endpackage

module mda_hour_counter #(
  parameter longint unsigned CYCLES_PER_HOUR = mda_pkg::HOUR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        count_en,
  input  wire logic        clear,
  output var  logic [15:0] hours_r,
  output var  logic [15:0] wraps_r,
  output var  logic        hour_tick_r
);
  import mda_pkg::*;

  logic [39:0] cyc_r;
  wire         hour_done = count_en && (cyc_r == 40'(CYCLES_PER_HOUR - 1));

  // Partial hours live only in cyc_r, so a reset drops them; a stop or a clear keeps them for the next run.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cyc_r       <= '0;
      hours_r     <= '0;
      wraps_r     <= '0;
      hour_tick_r <= 1'b0;
    end else if (clk_en) begin
      hour_tick_r <= hour_done;
      if (hour_done) cyc_r <= '0;
      else if (count_en) cyc_r <= cyc_r + 40'h1;
      if (hour_done) begin
        hours_r <= hours_r + 16'h1;
        if (hours_r == 16'hffff) wraps_r <= wraps_r + 16'h1;
      end else if (clear) begin
        hours_r <= '0;
      end
    end
  end

  property p_wrap;
    @(posedge core_clk) disable iff (reset)
      clk_en && hour_done && hours_r == 16'hffff |=> hours_r == 16'h0 && wraps_r == $past(wraps_r) + 16'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("hour counter did not wrap to zero");

  property p_idle;
    @(posedge core_clk) disable iff (reset)
      !count_en && !clear |=> $stable(hours_r);
  endproperty
  a_idle: assert property (p_idle) else $error("hours moved while not counting");
endmodule // mda_hour_counter

`default_nettype wire

// >>> mda_monitor_display.sv
// Monitor selection, panel display and hour and energy accumulators with an APB register port.
// Assumes APB master and drive status synchronous to core_clk; set_key is already debounced.
//
// Added by the designer: the APB slave port and the address map.
`default_nettype none

module mda_monitor_display #(
  parameter longint unsigned CYCLES_PER_HOUR = mda_pkg::HOUR_CYCLES,
  parameter int unsigned     KEY_HOLD_CYCLES = mda_pkg::HOLD_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic               set_key,
  input  wire mda_pkg::mda_drive_t drive,
  output var  mda_pkg::mda_panel_t panel
);
  import mda_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  logic [15:0] monitor_select_r, energy_range_r, energy_digit_shift_r;
  logic [23:0] energy_r;
  logic [15:0] on_hours, on_wraps, run_hours, run_wraps;
  logic        hour_tick;
  logic [23:0] panel_e_r, pu_e_r;
  logic [31:0] serial_e_r;
  mda_slot_t   slot_r, first_slot_r;

  wire setup_rd   = psel && !penable && !pready;
  wire wr_go      = psel && penable && pready && pwrite;
  wire wr_clr     = wr_go && paddr == ADDR_ENERGY_CLR;
  wire energy_clr = wr_clr && pwdata[15:0] == 16'h0;
  wire run_clr    = wr_go && paddr == ADDR_RUN_CLR && pwdata[15:0] == 16'h0;
  wire known      = paddr inside {ADDR_MON_SEL, ADDR_ENERGY_CLR, ADDR_SHIFT, ADDR_RUN_CLR,
                                  ADDR_ON_HOURS, ADDR_RUN_HOURS, ADDR_ENERGY, ADDR_PANEL_E,
                                  ADDR_PU_E, ADDR_SERIAL_E};
  logic [31:0] rd_mux;

  always_comb begin
    unique case (paddr)
      ADDR_MON_SEL:    rd_mux = {14'h0, first_slot_r, monitor_select_r};
      ADDR_ENERGY_CLR: rd_mux = {16'h0, energy_range_r};
      ADDR_SHIFT:      rd_mux = {16'h0, energy_digit_shift_r};
      ADDR_RUN_CLR:    rd_mux = {16'h0, RANGE_WIDE};
      ADDR_ON_HOURS:   rd_mux = {on_wraps, on_hours};
      ADDR_RUN_HOURS:  rd_mux = {run_wraps, run_hours};
      ADDR_ENERGY:     rd_mux = {8'h0, energy_r};
      ADDR_PANEL_E:    rd_mux = {8'h0, panel_e_r};
      ADDR_PU_E:       rd_mux = {8'h0, pu_e_r};
      ADDR_SERIAL_E:   rd_mux = serial_e_r;
      default:         rd_mux = 32'h0;
    endcase
  end

  // Every transfer answers after one access cycle; the read word is caught at setup.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (clk_en) begin
      pready  <= setup_rd;
      pslverr <= setup_rd && !known;
      if (setup_rd) prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      monitor_select_r     <= SEL_SEQ;
      energy_range_r       <= RANGE_WIDE;
      energy_digit_shift_r <= SHIFT_WRAP;
    end else if (clk_en && wr_go) begin
      if (paddr == ADDR_MON_SEL) monitor_select_r <= pwdata[15:0];
      if (paddr == ADDR_SHIFT) energy_digit_shift_r <= pwdata[15:0];
      if (wr_clr && !energy_clr) energy_range_r <= pwdata[15:0];
    end
  end

  // ****************************************
  // Hour and energy accumulators
  // ****************************************
  mda_hour_counter #(.CYCLES_PER_HOUR(CYCLES_PER_HOUR)) u_on_hours (
    .core_clk    (core_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .count_en    (1'b1),
    .clear       (1'b0),
    .hours_r     (on_hours),
    .wraps_r     (on_wraps),
    .hour_tick_r (hour_tick)
  );

  mda_hour_counter #(.CYCLES_PER_HOUR(CYCLES_PER_HOUR)) u_run_hours (
    .core_clk    (core_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .count_en    (drive.running && !drive.output_stop_input),
    .clear       (run_clr),
    .hours_r     (run_hours),
    .wraps_r     (run_wraps),
    .hour_tick_r ()
  );

  // One hour of output power in 0.01 kW is exactly 0.01 kWh per count.
  wire [24:0] e_sum    = {1'b0, energy_r} + {9'h0, drive.out_power};
  wire        e_over   = e_sum > {1'b0, ENERGY_MAX};
  wire        e_wrap   = energy_digit_shift_r == SHIFT_WRAP;
  wire [23:0] e_nxt    = !e_over ? e_sum[23:0] : (e_wrap ? 24'h0 : ENERGY_MAX);

  always_ff @(posedge core_clk) begin
    if (reset) energy_r <= '0;
    else if (clk_en && energy_clr) energy_r <= '0;
    else if (clk_en && hour_tick) energy_r <= e_nxt;
  end

  function automatic logic [23:0] shift_dec(input logic [23:0] v, input logic [15:0] n);
    logic [23:0] r;
    r = v;
    for (int i = 0; i < 4; i++) if (16'(i) < n && n <= SHIFT_MAX) r = r / E_TEN;
    return r;
  endfunction

  wire [23:0] e_sh    = shift_dec(energy_r, energy_digit_shift_r);
  wire [23:0] e_kwh   = e_sh / E_PER_KWH;
  wire [15:0] ser_max = energy_range_r == RANGE_SMALL ? PANEL_MAX : SERIAL_MAX;
  logic [23:0] panel_e_nxt, pu_e_nxt;

  always_comb begin
    if (e_sh <= PANEL_E_2DEC) panel_e_nxt = {3'h0, 1'b0, DEC_TWO, e_sh[17:0]};
    else if (e_sh <= PANEL_E_1DEC) panel_e_nxt = {4'h0, DEC_ONE, 18'(e_sh / E_TEN)};
    else if (e_sh <= PANEL_E_0DEC) panel_e_nxt = {4'h0, DEC_NONE, 18'(e_kwh)};
    else panel_e_nxt = {3'h0, 1'b1, DEC_NONE, 18'h0};
    if (e_sh <= PANEL_E_1DEC) pu_e_nxt = {4'h0, DEC_TWO, e_sh[17:0]};
    else if (e_sh <= PANEL_E_0DEC) pu_e_nxt = {4'h0, DEC_ONE, 18'(e_sh / E_TEN)};
    else pu_e_nxt = {4'h0, DEC_NONE, 18'(e_kwh)};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      panel_e_r  <= '0;
      pu_e_r     <= '0;
      serial_e_r <= '0;
    end else if (clk_en) begin
      panel_e_r  <= panel_e_nxt;
      pu_e_r     <= pu_e_nxt;
      serial_e_r <= {e_sh[15:0], (e_kwh > {8'h0, ser_max}) ? ser_max : e_kwh[15:0]};
    end
  end

  // ****************************************
  // Key handling and display slot
  // ****************************************
  logic        key_r, held_r;
  logic [31:0] hold_cnt_r;
  wire         hold_hit = set_key && key_r && !held_r && hold_cnt_r == KEY_HOLD_CYCLES - 1;
  wire         release_short = !set_key && key_r && !held_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      slot_r       <= SLOT_FREQ;
      first_slot_r <= SLOT_FREQ;
      key_r        <= 1'b0;
      held_r       <= 1'b0;
      hold_cnt_r   <= '0;
    end else if (clk_en) begin
      key_r      <= set_key;
      hold_cnt_r <= set_key && key_r ? hold_cnt_r + 32'h1 : 32'h0;
      held_r     <= set_key && (held_r || hold_hit);
      if (hold_hit) first_slot_r <= slot_r;
      if (release_short) slot_r <= mda_slot_t'(slot_r + 2'h1);
    end
  end

  // ****************************************
  // Display value selection
  // ****************************************
  logic [15:0] fault_freq_r;
  logic        fault_r;
  wire stopped     = !drive.running || drive.output_stop_input;
  wire set_stop    = monitor_select_r == SEL_SET_FREQ && stopped;
  wire [15:0] lim_hi = drive.set_freq > drive.max_freq ? drive.max_freq : drive.set_freq;
  wire [15:0] lim    = lim_hi < drive.min_freq ? drive.min_freq : lim_hi;
  wire [15:0] set_lim = (lim >= drive.jump_lo && lim < drive.jump_hi) ? drive.jump_lo : lim;
  wire [15:0] thermal = drive.motor_thermal > drive.transistor_thermal ?
                        drive.motor_thermal : drive.transistor_thermal;
  wire [15:0] on_wr   = on_hours >= HOUR_PANEL_WRAP ? on_hours - HOUR_PANEL_WRAP : on_hours;
  wire [15:0] run_wr  = run_hours >= HOUR_PANEL_WRAP ? run_hours - HOUR_PANEL_WRAP : run_hours;
  wire [15:0] therm_c = drive.thermistor_res < THERM_MIN ? THERM_MIN :
                        (drive.thermistor_res > THERM_MAX ? THERM_MAX : drive.thermistor_res);
  logic [15:0] val;
  logic [1:0]  dec;
  logic        force_dash, io_mode;

  always_comb begin
    val        = 16'h0;
    dec        = DEC_NONE;
    force_dash = 1'b0;
    io_mode    = 1'b0;
    unique case (slot_r)
      SLOT_FREQ: begin
        if (drive.autotune) val = drive.tuning_status;
        else if (drive.fault) val = fault_freq_r;
        else if (set_stop) val = set_lim;
        else val = drive.out_freq;
      end
      SLOT_CURRENT: val = drive.out_current;
      SLOT_FAULT:   val = {15'h0, drive.fault};
      SLOT_THIRD: begin
        unique case (monitor_select_r)
          SEL_THERMAL: val = thermal;
          SEL_ON_HOURS: begin
            val = on_wr / HOUR_PANEL_DIV;
            dec = DEC_TWO;
          end
          SEL_RUN_HOURS: begin
            val = run_wr / HOUR_PANEL_DIV;
            dec = DEC_TWO;
          end
          SEL_ENERGY: begin
            val        = panel_e_r[15:0];
            dec        = panel_e_r[19:18];
            force_dash = panel_e_r[20];
          end
          SEL_IO_MAP: io_mode = 1'b1;
          SEL_THERMISTOR: begin
            val = drive.motor_thermistor_on ? therm_c : 16'h0;
            dec = DEC_TWO;
          end
          default: val = drive.out_voltage;
        endcase
      end
    endcase
  end

  // The centre bar sits between the input row and the output row.
  wire [15:0] seg_nxt = {drive.in_terms[7:1], 1'b1, drive.out_terms};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_r      <= 1'b0;
      fault_freq_r <= '0;
      panel        <= '0;
    end else if (clk_en) begin
      fault_r <= drive.fault;
      if (drive.fault && !fault_r) fault_freq_r <= drive.out_freq;
      panel.dashes   <= force_dash || val > PANEL_MAX;
      panel.value    <= (force_dash || val > PANEL_MAX) ? 16'h0 : val;
      panel.decimals <= dec;
      panel.io_mode  <= io_mode;
      panel.segments <= io_mode ? seg_nxt : 16'h0;
      panel.hz_on    <= slot_r == SLOT_FREQ;
      panel.hz_flash <= slot_r == SLOT_FREQ && set_stop && !drive.autotune;
      panel.slot     <= slot_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_dash;
    @(posedge core_clk) disable iff (reset) panel.value <= PANEL_MAX;
  endproperty
  a_dash: assert property (p_dash) else $error("panel value above four digits");

  property p_thermal;
    @(posedge core_clk) disable iff (reset)
      clk_en && slot_r == SLOT_THIRD && monitor_select_r == SEL_THERMAL |=>
        panel.value == ($past(thermal) > PANEL_MAX ? 16'h0 : $past(thermal));
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal monitor not the larger");

  property p_flash;
    @(posedge core_clk) disable iff (reset)
      clk_en && slot_r == SLOT_FREQ && monitor_select_r == SEL_SET_FREQ && !drive.autotune &&
        (!drive.running || drive.output_stop_input) |=> panel.hz_flash;
  endproperty
  a_flash: assert property (p_flash) else $error("Hz not flashing while stopped");

  property p_steady;
    @(posedge core_clk) disable iff (reset)
      clk_en && drive.running && !drive.output_stop_input |=> !panel.hz_flash;
  endproperty
  a_steady: assert property (p_steady) else $error("Hz flashing while running");

  property p_clamp;
    @(posedge core_clk) disable iff (reset) energy_r <= ENERGY_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("energy past maximum");

  property p_clear;
    @(posedge core_clk) disable iff (reset) clk_en && energy_clr |=> energy_r == 24'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("energy not cleared");

  property p_range_read;
    @(posedge core_clk) disable iff (reset)
      psel && penable && pready && !pwrite && paddr == ADDR_ENERGY_CLR |-> prdata != 32'h0;
  endproperty
  a_range_read: assert property (p_range_read) else $error("range read as zero");

  property p_tune;
    @(posedge core_clk) disable iff (reset)
      clk_en && slot_r == SLOT_FREQ && drive.autotune && drive.tuning_status <= PANEL_MAX |=>
        panel.value == $past(drive.tuning_status);
  endproperty
  a_tune: assert property (p_tune) else $error("tuning status not shown");

  property p_energy_hold;
    @(posedge core_clk) disable iff (reset)
      !(clk_en && (hour_tick || energy_clr)) |=> $stable(energy_r);
  endproperty
  a_energy_hold: assert property (p_energy_hold) else $error("energy moved off the hour");
endmodule // mda_monitor_display

`default_nettype wire

// >>> mda_panel_keys.sv
// Behavioural front panel: presses the SET key short or long.
// Assumes the design samples the key on rising edges of core_clk.
`default_nettype none
module mda_panel_keys (
  input  wire logic core_clk,
  output var  logic set_key
);
  timeunit 1ns;
  timeprecision 1ps;
  initial set_key = 1'b0;
  // A hold past the key-hold count pins the first monitor and must not advance.
  task automatic press(input int hold);
    @(posedge core_clk);
    set_key <= 1'b1;
    repeat (hold) @(posedge core_clk);
    set_key <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // mda_panel_keys
`default_nettype wire

// >>> mda_monitor_display_tb_top.sv
// Self-checking bench of the monitor and display block.
// Assumes short hour and key-hold counts so the run stays brief.
`default_nettype none
module mda_monitor_display_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mda_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } mda_row_t;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        clk_en   = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        set_key;
  logic        er;
  mda_drive_t  drive    = '0;
  mda_panel_t  panel;
  mda_row_t    rows [20];
  int          num_errors = 0;
  int          n_checks   = 0;

  always #2 core_clk = ~core_clk;

  mda_monitor_display #(.CYCLES_PER_HOUR(20), .KEY_HOLD_CYCLES(5)) i_mda_monitor_display (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .set_key(set_key), .drive(drive), .panel(panel));
  mda_panel_keys i_mda_panel_keys (.core_clk(core_clk), .set_key(set_key));

  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pwait();
    repeat (3) @(posedge core_clk);
  endtask

  // The reads sample exactly 100 enabled edges apart, so the difference counts whole hours.
  // A frozen stretch in between must add nothing to it.
  task automatic hdiff(input logic [7:0] a, input logic [15:0] x, input int frz,
                       input string nm);
    logic [31:0] h0;
    logic [31:0] h1;
    logic        e;
    apb(1'b0, a, 32'h0, h0, e);
    if (frz > 0) begin
      clk_en <= 1'b0;
      repeat (frz) @(posedge core_clk);
      clk_en <= 1'b1;
    end
    repeat (97) @(posedge core_clk);
    apb(1'b0, a, 32'h0, h1, e);
    chk(nm, {16'h0, h1[15:0] - h0[15:0]}, {16'h0, x});
  endtask

  // 3060 cycles hold exactly 153 hour ticks, one past the energy maximum.
  task automatic erun(input logic [15:0] sh, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_SHIFT, {16'h0, sh}, r, e);
    apb(1'b1, ADDR_ENERGY_CLR, 32'h0, r, e);
    drive.out_power <= 16'hffff;
    repeat (3060) @(posedge core_clk);
    drive.out_power <= 16'h0;
    apb(1'b0, ADDR_ENERGY, 32'h0, r, e);
    chk("energy overflow", r, x);
  endtask

  initial begin
    rows = '{'{0, ADDR_MON_SEL, 0, 0, 0}, '{0, ADDR_ENERGY_CLR, 0, 32'h270f, 0},
      '{0, ADDR_SHIFT, 0, 32'h270f, 0}, '{0, ADDR_RUN_CLR, 0, 32'h270f, 0},
      '{1, ADDR_MON_SEL, 32'h64, 0, 0}, '{0, ADDR_MON_SEL, 0, 32'h64, 0},
      '{0, 8'h3c, 0, 0, 1}, '{1, 8'h40, 32'h5, 0, 1}, '{0, ADDR_ENERGY, 0, 32'h31f1, 0},
      '{0, ADDR_PANEL_E, 0, 32'h404fe, 0}, '{0, ADDR_PU_E, 0, 32'h831f1, 0},
      '{0, ADDR_SERIAL_E, 0, 32'h31f1007f, 0}, '{1, ADDR_SHIFT, 32'h2, 0, 0},
      '{0, ADDR_PANEL_E, 0, 32'h8007f, 0}, '{0, ADDR_PU_E, 0, 32'h8007f, 0},
      '{0, ADDR_SERIAL_E, 0, 32'h007f0001, 0}, '{1, ADDR_ENERGY_CLR, 0, 0, 0},
      '{0, ADDR_ENERGY_CLR, 0, 32'h270f, 0}, '{0, ADDR_ENERGY, 0, 0, 0},
      '{1, ADDR_RUN_CLR, 0, 0, 0}};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk("slot after reset", {30'h0, panel.slot}, 32'h0);
    drive.out_power <= 16'd12785;
    repeat (20) @(posedge core_clk);
    drive.out_power <= 16'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk("apb error", {31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) chk("apb data", rd, rows[i].q);
    end
    drive.running <= 1'b1;
    hdiff(ADDR_ON_HOURS, 16'h5, 60, "on hours");
    hdiff(ADDR_RUN_HOURS, 16'h5, 0, "run hours");
    drive.running <= 1'b0;
    hdiff(ADDR_RUN_HOURS, 16'h0, 0, "stopped hours");
    drive.max_freq <= 16'd6000;
    drive.set_freq <= 16'd3000;
    pwait();
    chk("set freq", {16'h0, panel.value}, 32'd3000);
    chk("hz flash", {31'h0, panel.hz_flash}, 32'h1);
    drive.running <= 1'b1;
    drive.out_freq <= 16'd2000;
    pwait();
    chk("out freq", {16'h0, panel.value}, 32'd2000);
    chk("hz steady", {31'h0, panel.hz_flash}, 32'h0);
    drive.output_stop_input <= 1'b1;
    pwait();
    chk("stop input", {16'h0, panel.value}, 32'd3000);
    drive.output_stop_input <= 1'b0;
    drive.fault <= 1'b1;
    pwait();
    drive.out_freq <= 16'd1000;
    pwait();
    chk("fault freq", {16'h0, panel.value}, 32'd2000);
    drive.fault <= 1'b0;
    drive.running <= 1'b0;
    drive.set_freq <= 16'd7000;
    pwait();
    chk("limited freq", {16'h0, panel.value}, 32'd6000);
    drive.jump_lo <= 16'd5000;
    drive.jump_hi <= 16'd6500;
    pwait();
    chk("jump freq", {16'h0, panel.value}, 32'd5000);
    i_mda_panel_keys.press(2);
    i_mda_panel_keys.press(2);
    chk("slot step", {30'h0, panel.slot}, 32'h2);
    apb(1'b1, ADDR_MON_SEL, {16'h0, SEL_THERMAL}, rd, er);
    drive.motor_thermal <= 16'd300;
    drive.transistor_thermal <= 16'd500;
    pwait();
    chk("thermal", {16'h0, panel.value}, 32'd500);
    drive.motor_thermal <= 16'd10000;
    pwait();
    chk("dashes", {31'h0, panel.dashes}, 32'h1);
    apb(1'b1, ADDR_MON_SEL, {16'h0, SEL_IO_MAP}, rd, er);
    drive.in_terms <= 8'ha4;
    drive.out_terms <= 8'h3c;
    pwait();
    chk("segments", {16'h0, panel.segments}, 32'ha53c);
    apb(1'b1, ADDR_MON_SEL, {16'h0, SEL_THERMISTOR}, rd, er);
    drive.motor_thermistor_on <= 1'b1;
    drive.thermistor_res <= 16'd5;
    pwait();
    chk("thermistor", {16'h0, panel.value}, 32'd10);
    i_mda_panel_keys.press(8);
    chk("long hold", {30'h0, panel.slot}, 32'h2);
    apb(1'b0, ADDR_MON_SEL, 32'h0, rd, er);
    chk("first monitor", rd, 32'h00020040);
    i_mda_panel_keys.press(2);
    i_mda_panel_keys.press(2);
    chk("slot wrap", {30'h0, panel.slot}, 32'h0);
    drive.autotune <= 1'b1;
    drive.tuning_status <= 16'd42;
    pwait();
    chk("tuning", {16'h0, panel.value}, 32'd42);
    drive.autotune <= 1'b0;
    erun(16'h2, 32'h0098967f);
    erun(SHIFT_WRAP, 32'h0);
    i_mda_panel_keys.press(2);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, ADDR_MON_SEL, 32'h0, rd, er);
    chk("reset select", rd, 32'h0);
    chk("reset slot", {30'h0, panel.slot}, 32'h0);
    results();
  end
endmodule // mda_monitor_display_tb_top
`default_nettype wire
